// ===== verilog/status_report.sv
`timescale 1ns/1ns
// Summary of operation
// - Error queue holds 20, oldest first
// - Error text at most 80 characters
// - Questionable mask gates questionable summary bit
// - Questionable mask reads back as weighted sum
// - Questionable events read back as weighted sum
// - Preset clears questionable enable mask
// - Clear status empties error queue and events
// - Standard mask gates standard summary bit
// - Standard mask reads back as weighted sum
// - Standard events read back as weighted sum
// - Complete command sets bit 0 when done
// - Complete query puts 1 in output buffer
// - Power-on clear setting decides standard and status byte mask clearing
// - Power-on clear setting reads 0 or 1
// - Status byte mask written by software
// - Status byte mask reads back as sum
// - Status query matches poll except bit 6 (MSS), keeps request
// - Device clear keeps status and settings
// - Device clear aborts, idles completion query, flushes buffers
// - Reading an event register clears it
// - Standard event bit assignment, others zero
// - Questionable bit assignment, others zero
module status_report
  import status_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RST_B_I,
  input wire logic [7:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [7:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  input wire logic BUSY_I,
  input wire logic QUERY_ERR_I,
  input wire logic DEV_ERR_I,
  input wire logic EXEC_ERR_I,
  input wire logic CMD_ERR_I,
  input wire logic [15:0] QUES_SET_I,
  input wire logic ERR_PUSH_I,
  input wire logic [15:0] ERR_CODE_I,
  input wire logic [6:0] ERR_LEN_I,
  input wire logic PSC_NV_I,
  input wire logic [7:0] ESE_NV_I,
  input wire logic [7:0] SRE_NV_I,
  input wire logic DEV_CLEAR_I,
  input wire logic SPOLL_I,
  output logic [7:0] SPOLL_BYTE_O,
  output logic SRQ_O,
  output logic PSC_O,
  output logic [7:0] ESE_O,
  output logic [7:0] SRE_O,
  output logic ABORT_O,
  output logic FLUSH_O
);
  typedef enum logic [1:0] {ST_INIT = 2'b01, ST_RUN = 2'b10} pwr_e;

  pwr_e st;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_full, w_full, wr_fire, rd_fire;
  logic [31:0] wmask, wr_cur, wv, rd_word;
  logic rd_hit, wr_hit;
  logic [7:0] esr, esr_set, stb_now;
  logic [15:0] ques_en, ques_evt;
  logic opc_pend, opcq_pend, opc_fire, reply_valid, underrun, mss_q;
  logic [7:0] reply_char;
  logic [22:0] errq [20];
  logic [4:0] rptr, wptr, err_cnt;
  logic push, pop, cls, preset, esr_rd, qev_rd, rpl_rd;

  // ----------------------------------------
  // Bus write channel
  // ----------------------------------------
  // Byte lane expansion of the write strobes
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wmask[8*b+:8] = {8{w_strb[b]}};
  end

  assign wr_fire = aw_full && w_full && !BVALID_O;

  // Address and data taken in either order, answered once both are held
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      AWREADY_O <= 1'b0;
      WREADY_O <= 1'b0;
      BVALID_O <= 1'b0;
      BRESP_O <= RESP_OKAY;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (AWVALID_I && AWREADY_O) begin
        aw_addr <= AWADDR_I;
        aw_full <= 1'b1;
        AWREADY_O <= 1'b0;
      end else if (!aw_full && !BVALID_O) begin
        AWREADY_O <= 1'b1;
      end
      if (WVALID_I && WREADY_O) begin
        w_data <= WDATA_I;
        w_strb <= WSTRB_I;
        w_full <= 1'b1;
        WREADY_O <= 1'b0;
      end else if (!w_full && !BVALID_O) begin
        WREADY_O <= 1'b1;
      end
      if (wr_fire) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        BVALID_O <= 1'b1;
        BRESP_O <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (BVALID_O && BREADY_I) begin
        BVALID_O <= 1'b0;
      end
    end
  end

  // Current value of the addressed writable register
  always_comb begin
    wr_hit = 1'b1;
    wr_cur = 32'h0000_0000;
    unique case (aw_addr)
      ADDR_CMD: wr_cur = 32'h0000_0000;
      ADDR_ESE: wr_cur = {24'h000000, ESE_O};
      ADDR_SRE: wr_cur = {24'h000000, SRE_O};
      ADDR_QEN: wr_cur = {16'h0000, ques_en};
      ADDR_PSC: wr_cur = {31'h00000000, PSC_O};
      default: wr_hit = 1'b0;
    endcase
  end

  assign wv = (wr_cur & ~wmask) | (w_data & wmask);
  assign cls = wr_fire && aw_addr == ADDR_CMD && wv[CMD_CLS];
  assign preset = wr_fire && aw_addr == ADDR_CMD && wv[CMD_PRESET];

  // ----------------------------------------
  // Bus read channel
  // ----------------------------------------
  assign rd_fire = ARVALID_I && ARREADY_O;
  assign esr_rd = rd_fire && ARADDR_I == ADDR_ESR;
  assign qev_rd = rd_fire && ARADDR_I == ADDR_QEV;
  assign rpl_rd = rd_fire && ARADDR_I == ADDR_RPL;

  // Read word selection, plain binary so software prints the weighted sum
  always_comb begin
    rd_hit = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (ARADDR_I)
      ADDR_CMD: rd_word = 32'h0000_0000;
      ADDR_ESE: rd_word = {24'h000000, ESE_O};
      ADDR_ESR: rd_word = {24'h000000, esr};
      ADDR_SRE: rd_word = {24'h000000, SRE_O};
      ADDR_STB: rd_word = {24'h000000, stb_now};
      ADDR_QEN: rd_word = {16'h0000, ques_en};
      ADDR_QEV: rd_word = {16'h0000, ques_evt};
      ADDR_PSC: rd_word = {31'h00000000, PSC_O};
      ADDR_ERR: rd_word = (err_cnt != 5'd0) ? {1'b1, 8'h00, errq[rptr]} : 32'h0000_0000;
      ADDR_RPL: rd_word = {23'h000000, reply_valid, (reply_valid ? reply_char : 8'h00)};
      ADDR_ERC: rd_word = {27'h0000000, err_cnt};
      default: rd_hit = 1'b0;
    endcase
  end

  // Single outstanding read, data registered on the same edge that takes the address
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ARREADY_O <= 1'b0;
      RVALID_O <= 1'b0;
      RDATA_O <= 32'h0000_0000;
      RRESP_O <= RESP_OKAY;
    end else if (rd_fire) begin
      ARREADY_O <= 1'b0;
      RVALID_O <= 1'b1;
      RDATA_O <= rd_word;
      RRESP_O <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (RVALID_O && RREADY_I) begin
      RVALID_O <= 1'b0;
    end else if (!RVALID_O) begin
      ARREADY_O <= 1'b1;
    end
  end

  // ----------------------------------------
  // Power-up and mask registers
  // ----------------------------------------
  // One init cycle after reset loads the stored settings
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      st <= ST_INIT;
      PSC_O <= 1'b0;
      ESE_O <= RST_BYTE;
      SRE_O <= RST_BYTE;
      ques_en <= RST_QUES;
    end else begin
      unique case (st)
        ST_INIT: begin
          st <= ST_RUN;
          PSC_O <= PSC_NV_I;
          ESE_O <= PSC_NV_I ? RST_BYTE : ESE_NV_I;
          SRE_O <= PSC_NV_I ? RST_BYTE : (SRE_NV_I & ~8'h40);
          ques_en <= RST_QUES;
        end
        ST_RUN: begin
          if (wr_fire && aw_addr == ADDR_ESE) ESE_O <= wv[7:0];
          if (wr_fire && aw_addr == ADDR_SRE) SRE_O <= wv[7:0] & ~8'h40;
          if (wr_fire && aw_addr == ADDR_PSC) PSC_O <= wv[0];
          if (preset) ques_en <= RST_QUES;
          else if (wr_fire && aw_addr == ADDR_QEN) ques_en <= wv[15:0];
        end
      endcase
    end
  end

  // ----------------------------------------
  // Event registers
  // ----------------------------------------
  // Event sources; a new event beats a same-cycle clear
  always_comb begin
    esr_set = 8'h00;
    esr_set[ESR_OPC] = opc_fire;
    esr_set[ESR_QYE] = QUERY_ERR_I || underrun;
    esr_set[ESR_DDE] = DEV_ERR_I;
    esr_set[ESR_EXE] = EXEC_ERR_I;
    esr_set[ESR_CME] = CMD_ERR_I;
    esr_set[ESR_PON] = st == ST_INIT;
  end

  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      esr <= RST_BYTE;
      ques_evt <= RST_QUES;
    end else begin
      esr <= ((cls || esr_rd) ? RST_BYTE : esr) | (esr_set & ESR_USED);
      ques_evt <= ((cls || qev_rd) ? RST_QUES : ques_evt) | (QUES_SET_I & QUES_USED);
    end
  end

  // ----------------------------------------
  // Operation complete and output buffer
  // ----------------------------------------
  assign opc_fire = opc_pend && !BUSY_I;
  assign underrun = rpl_rd && !reply_valid;

  // Completion waits until all earlier work is finished
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      opc_pend <= 1'b0;
      opcq_pend <= 1'b0;
      reply_valid <= 1'b0;
      reply_char <= RST_BYTE;
    end else begin
      if (wr_fire && aw_addr == ADDR_CMD && wv[CMD_OPC]) opc_pend <= 1'b1;
      else if (opc_fire) opc_pend <= 1'b0;
      if (DEV_CLEAR_I) begin
        opcq_pend <= 1'b0;
        reply_valid <= 1'b0;
      end else begin
        if (wr_fire && aw_addr == ADDR_CMD && wv[CMD_OPCQ]) opcq_pend <= 1'b1;
        else if (opcq_pend && !BUSY_I) opcq_pend <= 1'b0;
        if (opcq_pend && !BUSY_I) begin
          reply_valid <= 1'b1;
          reply_char <= OPC_REPLY;
        end else if (rpl_rd) begin
          reply_valid <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Error queue
  // ----------------------------------------
  assign pop = rd_fire && ARADDR_I == ADDR_ERR && err_cnt != 5'd0 && !cls;
  assign push = ERR_PUSH_I && (cls || pop || err_cnt != ERRQ_DEPTH);

  // Storage, text length clamped to the longest message
  always_ff @(posedge REF_CLK_I) begin
    if (push) begin
      errq[cls ? 5'd0 : wptr] <= {(ERR_LEN_I > ERR_TEXT_MAX) ? ERR_TEXT_MAX : ERR_LEN_I,
                                  ERR_CODE_I};
    end
  end

  // First-in first-out pointers
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rptr <= 5'd0;
      wptr <= 5'd0;
      err_cnt <= 5'd0;
    end else if (cls) begin
      rptr <= 5'd0;
      wptr <= push ? 5'd1 : 5'd0;
      err_cnt <= push ? 5'd1 : 5'd0;
    end else begin
      if (push) wptr <= (wptr == ERRQ_LAST) ? 5'd0 : wptr + 5'd1;
      if (pop) rptr <= (rptr == ERRQ_LAST) ? 5'd0 : rptr + 5'd1;
      if (push && !pop) err_cnt <= err_cnt + 5'd1;
      else if (pop && !push) err_cnt <= err_cnt - 5'd1;
    end
  end

  // ----------------------------------------
  // Status byte and service request
  // ----------------------------------------
  // Summary bits follow queue state or event AND mask without delay
  always_comb begin
    stb_now = 8'h00;
    stb_now[STB_EAV] = err_cnt != 5'd0;
    stb_now[STB_QUES] = |(ques_evt & ques_en);
    stb_now[STB_MAV] = reply_valid;
    stb_now[STB_ESB] = |(esr & ESE_O);
    stb_now[STB_MSS] = |(stb_now & SRE_O);
  end

  // Request latched on a rising summary, cleared by a serial poll or by clear status
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      mss_q <= 1'b0;
      SRQ_O <= 1'b0;
      SPOLL_BYTE_O <= RST_BYTE;
    end else begin
      mss_q <= stb_now[STB_MSS];
      if (stb_now[STB_MSS] && !mss_q) SRQ_O <= 1'b1;
      else if (SPOLL_I || cls) SRQ_O <= 1'b0;
      if (SPOLL_I) SPOLL_BYTE_O <= {stb_now[7], SRQ_O, stb_now[5:0]};
    end
  end

  // ----------------------------------------
  // Device clear
  // ----------------------------------------
  // Abort and flush pulses; status state is not touched here
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ABORT_O <= 1'b0;
      FLUSH_O <= 1'b0;
    end else begin
      ABORT_O <= DEV_CLEAR_I;
      FLUSH_O <= DEV_CLEAR_I;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_B_I);

  esr_clear_a: assert property (esr_rd && esr_set == 8'h00 |=> esr == 8'h00)
    else $error("event register not cleared by read");
  opc_set_a: assert property (opc_pend && !BUSY_I |=> esr[ESR_OPC] && !opc_pend)
    else $error("completion bit not set");
  opc_wait_a: assert property (opc_pend && BUSY_I |=> opc_pend)
    else $error("completion left pending early");
  reply_one_a: assert property (opcq_pend && !BUSY_I && !DEV_CLEAR_I
    |=> reply_valid && reply_char == OPC_REPLY)
    else $error("completion reply missing");
  stb_read_a: assert property (rd_fire && ARADDR_I == ADDR_STB && !SPOLL_I && !cls
    |=> RDATA_O[7:0] == $past(stb_now) && (SRQ_O == $past(SRQ_O) || $past(stb_now[STB_MSS])))
    else $error("status byte read wrong");
  preset_a: assert property (preset |=> ques_en == RST_QUES)
    else $error("preset left mask bits");
  cls_a: assert property (cls && QUES_SET_I == 16'h0000 ##0 esr_set == 8'h00
    |=> esr == 8'h00 && ques_evt == RST_QUES && !SRQ_O)
    else $error("clear status incomplete");
  dcl_keep_a: assert property (DEV_CLEAR_I && !wr_fire && st == ST_RUN
    |=> ESE_O == $past(ESE_O) && SRE_O == $past(SRE_O) && PSC_O == $past(PSC_O))
    else $error("device clear changed settings");
  dcl_flush_a: assert property (DEV_CLEAR_I |=> ABORT_O && FLUSH_O && !reply_valid)
    else $error("device clear not acted on");
  errq_depth_a: assert property (err_cnt <= ERRQ_DEPTH)
    else $error("error queue overfilled");
  pwr_clear_a: assert property (st == ST_INIT && PSC_NV_I
    |=> ESE_O == RST_BYTE && SRE_O == RST_BYTE && esr[ESR_PON])
    else $error("power-on clear not applied");
  bits_used_a: assert property ((esr & ~ESR_USED) == 8'h00
    && (ques_evt & ~QUES_USED) == RST_QUES)
    else $error("unassigned event bit set");

  opc_done_c: cover property (opc_pend ##1 opc_fire);
  errq_full_c: cover property (err_cnt == ERRQ_DEPTH);
  srq_rise_c: cover property (!SRQ_O ##1 SRQ_O);
  dcl_c: cover property (reply_valid ##1 DEV_CLEAR_I);
endmodule

// ===== verilog/status_pkg.sv
package status_pkg;
  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_ESE = 8'h04;
  localparam logic [7:0] ADDR_ESR = 8'h08;
  localparam logic [7:0] ADDR_SRE = 8'h0C;
  localparam logic [7:0] ADDR_STB = 8'h10;
  localparam logic [7:0] ADDR_QEN = 8'h14;
  localparam logic [7:0] ADDR_QEV = 8'h18;
  localparam logic [7:0] ADDR_PSC = 8'h1C;
  localparam logic [7:0] ADDR_ERR = 8'h20;
  localparam logic [7:0] ADDR_RPL = 8'h24;
  localparam logic [7:0] ADDR_ERC = 8'h28;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CMD_CLS = 0;
  localparam int CMD_OPC = 1;
  localparam int CMD_OPCQ = 2;
  localparam int CMD_PRESET = 3;
  localparam int ESR_OPC = 0;
  localparam int ESR_QYE = 2;
  localparam int ESR_DDE = 3;
  localparam int ESR_EXE = 4;
  localparam int ESR_CME = 5;
  localparam int ESR_PON = 7;
  localparam logic [7:0] ESR_USED = 8'hBD;
  localparam logic [15:0] QUES_USED = 16'h1A03;
  localparam int STB_EAV = 2;
  localparam int STB_QUES = 3;
  localparam int STB_MAV = 4;
  localparam int STB_ESB = 5;
  localparam int STB_MSS = 6;
  // ----------------------------------------
  // Sizes, values, reset values
  // ----------------------------------------
  localparam logic [4:0] ERRQ_DEPTH = 5'd20;
  localparam logic [4:0] ERRQ_LAST = 5'd19;
  localparam logic [6:0] ERR_TEXT_MAX = 7'd80;
  localparam logic [7:0] OPC_REPLY = 8'h31;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_QUES = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ===== testbench/host_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Remote host on the register bus
// ----------------------------------------
module host_model (
  input wire logic clk_i,
  output logic [7:0] awaddr_o,
  output logic awvalid_o,
  input wire logic awready_i,
  output logic [31:0] wdata_o,
  output logic [3:0] wstrb_o,
  output logic wvalid_o,
  input wire logic wready_i,
  input wire logic [1:0] bresp_i,
  input wire logic bvalid_i,
  output logic bready_o,
  output logic [7:0] araddr_o,
  output logic arvalid_o,
  input wire logic arready_i,
  input wire logic [31:0] rdata_i,
  input wire logic [1:0] rresp_i,
  input wire logic rvalid_i,
  output logic rready_o
);
  // Bus idle at time zero
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o, araddr_o, arvalid_o} = '0;
    rready_o = 1'h0;
  end

  // Write one word, address and data offered together
  task automatic wr_word(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                         output logic [1:0] r);
    @(posedge clk_i);
    awaddr_o <= a;
    wdata_o <= d;
    wstrb_o <= s;
    awvalid_o <= 1'h1;
    wvalid_o <= 1'h1;
    bready_o <= 1'h1;
    do begin
      @(posedge clk_i);
      if (awvalid_o && awready_i) awvalid_o <= 1'h0;
      if (wvalid_o && wready_i) wvalid_o <= 1'h0;
    end while (!bvalid_i);
    r = bresp_i;
    bready_o <= 1'h0;
  endtask

  // Read one word, held until the answer comes
  task automatic rd_word(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    araddr_o <= a;
    arvalid_o <= 1'h1;
    rready_o <= 1'h1;
    do begin
      @(posedge clk_i);
      if (arvalid_o && arready_i) arvalid_o <= 1'h0;
    end while (!rvalid_i);
    d = rdata_i;
    r = rresp_i;
    rready_o <= 1'h0;
  endtask
endmodule

// ===== testbench/instrument_status_reporting_tb_top.sv
`timescale 1ns/1ns
// ----------------------------------------
// Signals and instances
// ----------------------------------------
module instrument_status_reporting_tb_top
  import status_pkg::*;
;
  logic clk, rst_b, busy, q_err, d_err, x_err, c_err, push, psc_nv, dclr, spoll;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic srq, psc_live, abort, flush;
  logic [1:0] bresp, rresp, resp;
  logic [3:0] wstrb;
  logic [6:0] err_len;
  logic [7:0] awaddr, araddr, std_nv, sb_nv, spoll_byte, std_live, sb_live;
  logic [15:0] ques, err_code;
  logic [31:0] wdata, rdata, rd_val;
  int fails = 0;
  int checks_done = 0;

  status_report DUT (
    .REF_CLK_I(clk), .RST_B_I(rst_b), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
    .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid),
    .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
    .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
    .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready), .BUSY_I(busy),
    .QUERY_ERR_I(q_err), .DEV_ERR_I(d_err), .EXEC_ERR_I(x_err), .CMD_ERR_I(c_err),
    .QUES_SET_I(ques), .ERR_PUSH_I(push), .ERR_CODE_I(err_code), .ERR_LEN_I(err_len),
    .PSC_NV_I(psc_nv), .ESE_NV_I(std_nv), .SRE_NV_I(sb_nv), .DEV_CLEAR_I(dclr),
    .SPOLL_I(spoll), .SPOLL_BYTE_O(spoll_byte), .SRQ_O(srq), .PSC_O(psc_live),
    .ESE_O(std_live), .SRE_O(sb_live), .ABORT_O(abort), .FLUSH_O(flush)
  );

  host_model host (
    .clk_i(clk), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
    .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid), .wready_i(wready),
    .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr),
    .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp),
    .rvalid_i(rvalid), .rready_o(rready)
  );

  // Clock, 4 ns period
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------
  // Helper tasks
  // ----------------------------------------
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // Register access through the host
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    host.rd_word(a, rd_val, resp);
    check(rd_val, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.wr_word(a, d, 4'hF, resp);
    check(32'(resp), 32'(RESP_OKAY));
  endtask

  // One-cycle event pulses
  task automatic ev(input logic [3:0] e, input logic [15:0] q);
    @(posedge clk);
    {c_err, x_err, d_err, q_err} <= e;
    ques <= q;
    @(posedge clk);
    {c_err, x_err, d_err, q_err} <= 4'h0;
    ques <= 16'h0000;
  endtask

  // Record one error entry
  task automatic push_err(input logic [15:0] c, input logic [6:0] l);
    @(posedge clk);
    push <= 1'h1;
    err_code <= c;
    err_len <= l;
    @(posedge clk);
    push <= 1'h0;
  endtask

  // Power-up with given stored settings
  task automatic do_reset(input logic p, input logic [7:0] s, input logic [7:0] b);
    @(posedge clk);
    psc_nv <= p;
    std_nv <= s;
    sb_nv <= b;
    rst_b <= 1'h0;
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_power();
    do_reset(1'h1, 8'hFF, 8'hFF);
    rd_chk(ADDR_ESE, 32'h0);
    rd_chk(ADDR_SRE, 32'h0);
    rd_chk(ADDR_PSC, 32'h1);
    rd_chk(ADDR_ESR, 32'h80);
    rd_chk(ADDR_ESR, 32'h0);
    do_reset(1'h0, 8'h38, 8'h3C);
    rd_chk(ADDR_ESE, 32'h38);
    rd_chk(ADDR_SRE, 32'h3C);
    rd_chk(ADDR_PSC, 32'h0);
    check(32'({psc_live, std_live, sb_live}), 32'h383C);
    rd_chk(ADDR_ESR, 32'h80);
    wr(ADDR_PSC, 32'h1);
    rd_chk(ADDR_PSC, 32'h1);
    $display("t_power done");
  endtask

  task automatic t_std();
    wr(ADDR_ESE, 32'h20);
    rd_chk(ADDR_ESE, 32'h20);
    ev(4'h1, 16'h0000);
    rd_chk(ADDR_STB, 32'h0);
    ev(4'h8, 16'h0000);
    rd_chk(ADDR_STB, 32'h60);
    rd_chk(ADDR_ESR, 32'h24);
    rd_chk(ADDR_STB, 32'h0);
    ev(4'hF, 16'h0000);
    rd_chk(ADDR_ESR, 32'h3C);
    $display("t_std done");
  endtask

  task automatic t_ques();
    wr(ADDR_QEN, 32'h200);
    rd_chk(ADDR_QEN, 32'h200);
    host.wr_word(ADDR_QEN, 32'h0000_FFFF, 4'h1, resp);
    check(32'(resp), 32'(RESP_OKAY));
    rd_chk(ADDR_QEN, 32'h2FF);
    ev(4'h0, 16'hFFFF);
    rd_chk(ADDR_STB, 32'h48);
    wr(ADDR_CMD, 32'h1 << CMD_PRESET);
    rd_chk(ADDR_QEN, 32'h0);
    rd_chk(ADDR_STB, 32'h0);
    rd_chk(ADDR_QEV, 32'h1A03);
    rd_chk(ADDR_QEV, 32'h0);
    $display("t_ques done");
  endtask

  task automatic t_opc();
    @(posedge clk);
    busy <= 1'h1;
    wr(ADDR_CMD, 32'h1 << CMD_OPC);
    repeat (4) @(posedge clk);
    rd_chk(ADDR_ESR, 32'h0);
    @(posedge clk);
    busy <= 1'h0;
    rd_chk(ADDR_ESR, 32'h1);
    @(posedge clk);
    busy <= 1'h1;
    wr(ADDR_CMD, 32'h1 << CMD_OPCQ);
    rd_chk(ADDR_RPL, 32'h0);
    @(posedge clk);
    busy <= 1'h0;
    repeat (2) @(posedge clk);
    rd_chk(ADDR_RPL, 32'h100 | 32'(OPC_REPLY));
    rd_chk(ADDR_ESR, 32'h1 << ESR_QYE);
    $display("t_opc done");
  endtask

  task automatic t_errq();
    push_err(16'h0101, 7'h64);
    push_err(16'h0202, 7'h05);
    rd_chk(ADDR_ERC, 32'h2);
    rd_chk(ADDR_ERR, {1'h1, 8'h00, ERR_TEXT_MAX, 16'h0101});
    rd_chk(ADDR_ERR, {1'h1, 8'h00, 7'h05, 16'h0202});
    rd_chk(ADDR_ERR, 32'h0);
    for (int i = 0; i < 22; i++) begin
      push_err(16'(i), 7'h01);
    end
    rd_chk(ADDR_ERC, 32'(ERRQ_DEPTH));
    rd_chk(ADDR_ERR, {1'h1, 8'h00, 7'h01, 16'h0000});
    ev(4'hF, 16'h0001);
    wr(ADDR_CMD, 32'h1 << CMD_CLS);
    rd_chk(ADDR_ESR, 32'h0);
    rd_chk(ADDR_QEV, 32'h0);
    rd_chk(ADDR_STB, 32'h0);
    rd_chk(ADDR_ERC, 32'h0);
    $display("t_errq done");
  endtask

  task automatic t_srq();
    wr(ADDR_SRE, 32'hFF);
    rd_chk(ADDR_SRE, 32'hBF);
    ev(4'h8, 16'h0000);
    repeat (2) @(posedge clk);
    check(32'(srq), 32'h1);
    rd_chk(ADDR_STB, 32'h60);
    check(32'(srq), 32'h1);
    @(posedge clk);
    spoll <= 1'h1;
    @(posedge clk);
    spoll <= 1'h0;
    @(posedge clk);
    #1;
    check(32'({srq, spoll_byte}), 32'h060);
    wr(ADDR_SRE, 32'h0);
    rd_chk(ADDR_STB, 32'h20);
    rd_chk(ADDR_ESR, 32'h20);
    $display("t_srq done");
  endtask

  task automatic t_dclr();
    logic [31:0] hits;
    ev(4'h2, 16'h0000);
    push_err(16'h0303, 7'h02);
    wr(ADDR_CMD, 32'h1 << CMD_OPCQ);
    @(posedge clk);
    dclr <= 1'h1;
    @(posedge clk);
    dclr <= 1'h0;
    hits = 32'h0;
    repeat (3) begin
      #1;
      hits = hits + 32'(abort) + 32'(flush);
      @(posedge clk);
    end
    check(hits, 32'h2);
    rd_chk(ADDR_ESE, 32'h20);
    rd_chk(ADDR_ERC, 32'h1);
    rd_chk(ADDR_ESR, 32'h08);
    rd_chk(ADDR_RPL, 32'h0);
    host.rd_word(8'h3C, rd_val, resp);
    check(32'(resp), 32'(RESP_SLVERR));
    check(rd_val, 32'h0);
    $display("t_dclr done");
  endtask

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rst_b = 1'h0;
    {busy, q_err, d_err, x_err, c_err, push, psc_nv, dclr, spoll} = '0;
    {ques, err_code, err_len, std_nv, sb_nv} = '0;
    t_power();
    t_std();
    t_ques();
    t_opc();
    t_errq();
    t_srq();
    t_dclr();
    tally_and_finish();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("ERROR at %0t: watchdog expired", $time);
    tally_and_finish();
  end
endmodule
